// File: dac_regs_pkg.sv
// register map, field positions and reset values of the dac input/datapath register section
// assumes an 8-bit address and 8-bit data control port decoded upstream
package dac_regs_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_INPUT_LEVEL = 8'h15;
  localparam logic [7:0] OFS_STROBE_DELAY = 8'h16;
  localparam logic [7:0] OFS_FIFO_PHASE = 8'h17;
  localparam logic [7:0] OFS_FIFO_FLAGS = 8'h18;
  localparam logic [7:0] OFS_FIFO_LEVEL = 8'h19;
  localparam logic [7:0] OFS_DATAPATH = 8'h1b;
  localparam logic [7:0] OFS_HB1 = 8'h1c;

  // ==========================================================
  // field positions
  localparam int BIT_LVL_HIGH = 1;
  localparam int BIT_LVL_LOW = 0;
  localparam int BIT_WARN1 = 7;
  localparam int BIT_WARN2 = 6;
  localparam int BIT_ALIGN_ACK = 2;
  localparam int BIT_ALIGN_REQ = 1;
  localparam int BIT_BYP_PREMOD = 7;
  localparam int BIT_BYP_SINC = 6;
  localparam int BIT_BYP_OSC = 5;
  localparam int BIT_OSC_HALF = 3;
  localparam int BIT_BYP_PHASE = 2;
  localparam int BIT_LOW_SIDE = 1;
  localparam int BIT_I_TO_Q = 0;
  localparam int BIT_HB1_BYPASS = 0;
  localparam int HB1_MODE_LSB = 1;

  // ==========================================================
  // reset values
  localparam logic [1:0] RST_STROBE_DELAY = 2'h0;
  localparam logic [2:0] RST_FIFO_PHASE = 3'h4;
  localparam logic [7:0] RST_DATAPATH = 8'he4;
  localparam logic [1:0] RST_HB1_MODE = 2'h0;
  localparam logic RST_HB1_BYPASS = 1'b0;
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam logic [3:0] STROBE_REV_MIN = 4'h2;

  // host access to the register section
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // datapath configuration driven to the converter logic
  typedef struct packed {
    logic byp_premod;
    logic byp_sinc;
    logic byp_osc;
    logic osc_half_gain;
    logic byp_phase_dc;
    logic low_side_image;
    logic i_to_q;
    logic q_clk_en;
    logic [1:0] hb1_mode;
    logic hb1_modulate;
    logic hb1_bypass;
  } dp_cfg_t;

endpackage

// File: dac_input_fifo_datapath_regs.sv
// register section for the input level flags, strobe delay, fifo phase and datapath options
// assumes reg_req is a decoded single-cycle access from the serial control port, and that the
// fifo pointers and lane level comparators are synchronous to clk
//
// Functional notes
// - sticky high/low flags from lane level comparators
// - two-bit strobe delay field, resets to zero
// - strobe delay applies only from revision two
// - three-bit pointer offset loaded on fifo reset
// - warning one when pointers within one
// - warning two when pointers within two
// - writing align request starts pointer realignment
// - acknowledge bit set once pointers aligned
// - read-only thermometer fifo fill level
// - four stage bypass bits, reset to one
// - oscillator half gain bit, reset clear
// - sideband select, zero high-side image
// - i-to-q ignores q, stops q clocks
// - first half-band two-bit mode field, reset zero
// - modes two and three modulate, passband 1.1 to 1.9
// - first half-band bypass bit, reset zero
module dac_input_fifo_datapath_regs #(
  parameter int LANES = 14,
  parameter int PTR_W = 3,
  parameter logic [3:0] SILICON_REV = 4'h2 // arbitrary default revision
) (
  input wire logic clk, // 10 MHz control clock
  input wire logic rst, // synchronous, active high
  input wire dac_regs_pkg::reg_req_t reg_req, // decoded control port access
  output logic [7:0] rdata_r, // read data, valid the cycle after rd
  output logic rvalid_r, // read data valid pulse
  input wire logic [LANES-1:0] lane_above_hi, // lane comparator: above 1.7 V
  input wire logic [LANES-1:0] lane_below_lo, // lane comparator: below 0.7 V
  input wire logic [PTR_W-1:0] fifo_wr_ptr, // fifo write pointer
  input wire logic [PTR_W-1:0] fifo_rd_ptr, // fifo read pointer
  output logic fifo_soft_reset_r, // one-cycle fifo reset pulse
  output logic [2:0] fifo_phase_offset_r, // pointer offset loaded on reset
  output logic [1:0] strobe_delay_sel_r, // applied sample strobe delay code
  output logic strobe_delay_en_r, // selectable delay in force
  output dac_regs_pkg::dp_cfg_t dp_cfg_r // datapath configuration
);

  localparam int DEPTH = 1 << PTR_W;

  // ==========================================================
  // helpers
  // circular distance between pointers, the nearer way round
  function automatic logic [PTR_W-1:0] ptr_gap(input logic [PTR_W-1:0] a,
                                              input logic [PTR_W-1:0] b);
    logic [PTR_W-1:0] d;
    logic [PTR_W-1:0] e;
    d = a - b;
    e = b - a;
    ptr_gap = (d < e) ? d : e;
  endfunction

  function automatic logic is_wr(input dac_regs_pkg::reg_req_t r, input logic [7:0] ofs);
    is_wr = r.wr && (r.addr == ofs);
  endfunction

  function automatic logic is_rd(input dac_regs_pkg::reg_req_t r, input logic [7:0] ofs);
    is_rd = r.rd && (r.addr == ofs);
  endfunction

  typedef enum logic [1:0] {AL_IDLE, AL_RESET, AL_WAIT, AL_DONE} align_st_t;

  logic lvl_high_r;
  logic lvl_low_r;
  logic [1:0] strobe_field_r;
  logic align_req_r;
  logic align_ack_r;
  align_st_t align_st_r;
  logic [7:0] dp_reg_r;
  logic [1:0] hb1_mode_r;
  logic hb1_bypass_r;
  logic [PTR_W-1:0] gap;
  logic [PTR_W-1:0] fill;
  logic [7:0] level_therm;
  logic [7:0] rd_mux;
  logic rev_ok;

  assign gap = ptr_gap(fifo_wr_ptr, fifo_rd_ptr);
  assign fill = fifo_wr_ptr - fifo_rd_ptr;
  assign rev_ok = (SILICON_REV >= dac_regs_pkg::STROBE_REV_MIN);

  // ==========================================================
  // input level flags
  // sticky so a short excursion is not missed; cleared by reading, a new event wins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lvl_high_r <= 1'b0;
      lvl_low_r <= 1'b0;
    end
    else
    begin
      if (|lane_above_hi)
        lvl_high_r <= 1'b1;
      else if (is_rd(reg_req, dac_regs_pkg::OFS_INPUT_LEVEL))
        lvl_high_r <= 1'b0;
      if (|lane_below_lo)
        lvl_low_r <= 1'b1;
      else if (is_rd(reg_req, dac_regs_pkg::OFS_INPUT_LEVEL))
        lvl_low_r <= 1'b0;
    end
  end

  // ==========================================================
  // sample strobe delay
  always_ff @(posedge clk)
  begin
    if (rst)
      strobe_field_r <= dac_regs_pkg::RST_STROBE_DELAY;
    else if (is_wr(reg_req, dac_regs_pkg::OFS_STROBE_DELAY))
      strobe_field_r <= reg_req.wdata[1:0];
  end

  // older silicon keeps the fixed strobe path whatever is programmed
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      strobe_delay_sel_r <= dac_regs_pkg::RST_STROBE_DELAY;
      strobe_delay_en_r <= 1'b0;
    end
    else
    begin
      strobe_delay_sel_r <= rev_ok ? strobe_field_r : dac_regs_pkg::RST_STROBE_DELAY;
      strobe_delay_en_r <= rev_ok;
    end
  end

  // ==========================================================
  // fifo phase offset
  // the host is expected to leave this at four; any value is accepted
  always_ff @(posedge clk)
  begin
    if (rst)
      fifo_phase_offset_r <= dac_regs_pkg::RST_FIFO_PHASE;
    else if (is_wr(reg_req, dac_regs_pkg::OFS_FIFO_PHASE))
      fifo_phase_offset_r <= reg_req.wdata[2:0];
  end

  // ==========================================================
  // soft alignment
  // request bit is host owned; writing 1 from 0 starts one realignment
  always_ff @(posedge clk)
  begin
    if (rst)
      align_req_r <= 1'b0;
    else if (is_wr(reg_req, dac_regs_pkg::OFS_FIFO_FLAGS))
      align_req_r <= reg_req.wdata[dac_regs_pkg::BIT_ALIGN_REQ];
  end

  // reset pulse, then wait until the pointers show the programmed offset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      align_st_r <= AL_IDLE;
      fifo_soft_reset_r <= 1'b0;
      align_ack_r <= 1'b0;
    end
    else
    begin
      fifo_soft_reset_r <= 1'b0;
      case (align_st_r)
        AL_IDLE:
        begin
          if (is_wr(reg_req, dac_regs_pkg::OFS_FIFO_FLAGS)
              && reg_req.wdata[dac_regs_pkg::BIT_ALIGN_REQ])
          begin
            align_ack_r <= 1'b0;
            align_st_r <= AL_RESET;
          end
        end
        AL_RESET:
        begin
          fifo_soft_reset_r <= 1'b1;
          align_st_r <= AL_WAIT;
        end
        AL_WAIT:
        begin
          if (fill == PTR_W'(fifo_phase_offset_r))
          begin
            align_ack_r <= 1'b1;
            align_st_r <= AL_DONE;
          end
        end
        AL_DONE:
        begin
          // a fresh request needs the bit taken back to 0 first
          if (!align_req_r)
            align_st_r <= AL_IDLE;
        end
        default:
          align_st_r <= AL_IDLE;
      endcase
    end
  end

  // ==========================================================
  // fill level as thermometer code, one bit per occupied slot
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_therm
      if (gi < DEPTH)
        assign level_therm[gi] = (32'(fill) > gi);
      else
        assign level_therm[gi] = 1'b0;
    end
  endgenerate

  // ==========================================================
  // datapath options and first half-band stage
  always_ff @(posedge clk)
  begin
    if (rst)
      dp_reg_r <= dac_regs_pkg::RST_DATAPATH;
    else if (is_wr(reg_req, dac_regs_pkg::OFS_DATAPATH))
      dp_reg_r <= reg_req.wdata & dac_regs_pkg::RST_DATAPATH | (reg_req.wdata & 8'h0b);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hb1_mode_r <= dac_regs_pkg::RST_HB1_MODE;
      hb1_bypass_r <= dac_regs_pkg::RST_HB1_BYPASS;
    end
    else if (is_wr(reg_req, dac_regs_pkg::OFS_HB1))
    begin
      hb1_mode_r <= reg_req.wdata[dac_regs_pkg::HB1_MODE_LSB +: 2];
      hb1_bypass_r <= reg_req.wdata[dac_regs_pkg::BIT_HB1_BYPASS];
    end
  end

  // configuration outputs, registered so the datapath sees clean levels
  always_ff @(posedge clk)
  begin
    if (rst)
      dp_cfg_r <= '0;
    else
    begin
      dp_cfg_r.byp_premod <= dp_reg_r[dac_regs_pkg::BIT_BYP_PREMOD];
      dp_cfg_r.byp_sinc <= dp_reg_r[dac_regs_pkg::BIT_BYP_SINC];
      dp_cfg_r.byp_osc <= dp_reg_r[dac_regs_pkg::BIT_BYP_OSC];
      dp_cfg_r.byp_phase_dc <= dp_reg_r[dac_regs_pkg::BIT_BYP_PHASE];
      dp_cfg_r.osc_half_gain <= dp_reg_r[dac_regs_pkg::BIT_OSC_HALF];
      dp_cfg_r.low_side_image <= dp_reg_r[dac_regs_pkg::BIT_LOW_SIDE];
      dp_cfg_r.i_to_q <= dp_reg_r[dac_regs_pkg::BIT_I_TO_Q];
      dp_cfg_r.q_clk_en <= !dp_reg_r[dac_regs_pkg::BIT_I_TO_Q];
      dp_cfg_r.hb1_mode <= hb1_mode_r;
      dp_cfg_r.hb1_modulate <= hb1_mode_r[1];
      dp_cfg_r.hb1_bypass <= hb1_bypass_r;
    end
  end

  // ==========================================================
  // readback; status and level have no write path at all
  always_comb
  begin
    rd_mux = 8'h00;
    case (reg_req.addr)
      dac_regs_pkg::OFS_INPUT_LEVEL:
      begin
        rd_mux[dac_regs_pkg::BIT_LVL_HIGH] = lvl_high_r;
        rd_mux[dac_regs_pkg::BIT_LVL_LOW] = lvl_low_r;
      end
      dac_regs_pkg::OFS_STROBE_DELAY:
        rd_mux[1:0] = strobe_field_r;
      dac_regs_pkg::OFS_FIFO_PHASE:
        rd_mux[2:0] = fifo_phase_offset_r;
      dac_regs_pkg::OFS_FIFO_FLAGS:
      begin
        rd_mux[dac_regs_pkg::BIT_WARN1] = (gap <= PTR_W'(1));
        rd_mux[dac_regs_pkg::BIT_WARN2] = (gap <= PTR_W'(2));
        rd_mux[dac_regs_pkg::BIT_ALIGN_ACK] = align_ack_r;
        rd_mux[dac_regs_pkg::BIT_ALIGN_REQ] = align_req_r;
      end
      dac_regs_pkg::OFS_FIFO_LEVEL:
        rd_mux = level_therm;
      dac_regs_pkg::OFS_DATAPATH:
        rd_mux = dp_reg_r & 8'hef;
      dac_regs_pkg::OFS_HB1:
        rd_mux = {5'h00, hb1_mode_r, hb1_bypass_r};
      default:
        rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_r <= dac_regs_pkg::RST_RDATA;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= reg_req.rd;
      if (reg_req.rd)
        rdata_r <= rd_mux;
    end
  end

endmodule

// File: dac_regs_props.sv
// checker on the top ports of the dac register section, bound below
// assumes one clock and a synchronous active-high reset
module dac_regs_props #(
  parameter int LANES = 14,
  parameter int PTR_W = 3,
  parameter logic [3:0] SILICON_REV = 4'h2
) (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire dac_regs_pkg::reg_req_t reg_req, // host access
  input wire logic [7:0] rdata_r, // read data
  input wire logic rvalid_r, // read valid
  input wire logic [LANES-1:0] lane_above_hi, // lanes high
  input wire logic [LANES-1:0] lane_below_lo, // lanes low
  input wire logic [PTR_W-1:0] fifo_wr_ptr, // write pointer
  input wire logic [PTR_W-1:0] fifo_rd_ptr, // read pointer
  input wire logic fifo_soft_reset_r, // realign pulse
  input wire logic [2:0] fifo_phase_offset_r, // offset
  input wire logic [1:0] strobe_delay_sel_r, // delay code
  input wire logic strobe_delay_en_r, // delay in force
  input wire dac_regs_pkg::dp_cfg_t dp_cfg_r // datapath config
);
  // ==========================================
  // setup
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [2:0] gap;
  // pointer gap; ##2 below leaves room for a config output registered once more
  assign gap = 3'(fifo_wr_ptr - fifo_rd_ptr);
  property p_strobe;
    logic [1:0] d;
    (reg_req.wr && reg_req.addr == dac_regs_pkg::OFS_STROBE_DELAY, d = reg_req.wdata[1:0])
      |-> ##2 strobe_delay_sel_r == (SILICON_REV >= dac_regs_pkg::STROBE_REV_MIN ? d : 2'h0);
  endproperty
  property p_phase;
    logic [2:0] d;
    (reg_req.wr && reg_req.addr == dac_regs_pkg::OFS_FIFO_PHASE, d = reg_req.wdata[2:0])
      |-> ##2 fifo_phase_offset_r == d;
  endproperty
  property p_level;
    logic [2:0] g;
    (reg_req.rd && reg_req.addr == dac_regs_pkg::OFS_FIFO_LEVEL, g = gap)
      |=> rvalid_r && rdata_r == (8'h01 << g) - 8'h01;
  endproperty
  property p_warn;
    logic [2:0] g;
    (reg_req.rd && reg_req.addr == dac_regs_pkg::OFS_FIFO_FLAGS, g = gap)
      |=> rdata_r[7] == (g <= 3'd1 || g == 3'd7) && rdata_r[6] == (g <= 3'd2 || g >= 3'd6);
  endproperty
  property p_dp;
    logic [7:0] d;
    (reg_req.wr && reg_req.addr == dac_regs_pkg::OFS_DATAPATH, d = reg_req.wdata)
      |-> ##2 dp_cfg_r.byp_premod == d[7] && dp_cfg_r.osc_half_gain == d[3]
      && dp_cfg_r.low_side_image == d[1];
  endproperty
  // ==========================================
  // assertions
  a_strobe_follow: assert property (p_strobe)
    else $error("strobe delay code wrong");
  a_phase_follow: assert property (p_phase)
    else $error("phase offset wrong");
  a_strobe_enable: assert property (!$past(rst)
    |-> strobe_delay_en_r == (SILICON_REV >= dac_regs_pkg::STROBE_REV_MIN))
    else $error("strobe enable wrong");
  a_level_code: assert property (p_level)
    else $error("fill level wrong");
  a_warn_flags: assert property (p_warn)
    else $error("warning flags wrong");
  a_pulse_single: assert property (fifo_soft_reset_r |=> !fifo_soft_reset_r)
    else $error("realign pulse too long");
  // the request edge lies two samples back: state step, then the registered pulse
  a_pulse_cause: assert property ($rose(fifo_soft_reset_r) |-> $past(reg_req.wr, 2)
    && $past(reg_req.addr, 2) == dac_regs_pkg::OFS_FIFO_FLAGS
    && $past(reg_req.wdata[1], 2))
    else $error("realign pulse without request");
  a_q_clock_off: assert property (dp_cfg_r.i_to_q |-> !dp_cfg_r.q_clk_en)
    else $error("q clocks run in i-to-q");
  a_hb1_modulate: assert property (dp_cfg_r.hb1_modulate == dp_cfg_r.hb1_mode[1])
    else $error("half-band modulation wrong");
  a_dp_follow: assert property (p_dp)
    else $error("datapath config wrong");
  c_realign: cover property (fifo_soft_reset_r);
  c_i_to_q: cover property (dp_cfg_r.i_to_q);
  c_warn_read: cover property (rvalid_r && rdata_r[7]);
endmodule
bind dac_input_fifo_datapath_regs dac_regs_props #(.LANES(LANES), .PTR_W(PTR_W),
  .SILICON_REV(SILICON_REV)) dac_regs_props_inst (.clk(clk), .rst(rst), .reg_req(reg_req),
  .rdata_r(rdata_r), .rvalid_r(rvalid_r), .lane_above_hi(lane_above_hi),
  .lane_below_lo(lane_below_lo), .fifo_wr_ptr(fifo_wr_ptr), .fifo_rd_ptr(fifo_rd_ptr),
  .fifo_soft_reset_r(fifo_soft_reset_r), .fifo_phase_offset_r(fifo_phase_offset_r),
  .strobe_delay_sel_r(strobe_delay_sel_r), .strobe_delay_en_r(strobe_delay_en_r),
  .dp_cfg_r(dp_cfg_r));

// File: fifo_ptr_model.sv
// model of the fifo pointers behind the register section
// assumes the bench may force a gap and the design pulses a realign
module fifo_ptr_model #(
  parameter int PTR_W = 3
) (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic soft_reset, // realign pulse
  input wire logic [2:0] offset, // gap loaded on realign
  input wire logic gap_set, // bench forces a gap
  input wire logic [PTR_W-1:0] gap_val, // forced gap
  output logic [PTR_W-1:0] wr_ptr, // write pointer
  output logic [PTR_W-1:0] rd_ptr // read pointer
);
  // ==========================================
  // pointers
  logic [PTR_W-1:0] gap_r;
  // read side free runs so pointer values keep moving like real traffic
  always_ff @(posedge clk)
  begin
    if (rst)
      rd_ptr <= '0;
    else
      rd_ptr <= rd_ptr + 1'b1;
  end
  // gap starts at two so warning one is not idle-true out of reset; warning two is set at this gap
  always_ff @(posedge clk)
  begin
    if (rst)
      gap_r <= PTR_W'(2);
    else if (soft_reset)
      gap_r <= PTR_W'(offset);
    else if (gap_set)
      gap_r <= gap_val;
  end
  assign wr_ptr = rd_ptr + gap_r;
endmodule

// File: dac_input_fifo_datapath_regs_tb_top.sv
// bench for the dac register section, host accesses driven at the falling edge
// assumes the pointer model stands in for the fifo
module dac_input_fifo_datapath_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  dac_regs_pkg::reg_req_t req;
  dac_regs_pkg::dp_cfg_t dp;
  logic [7:0] rdata;
  logic rvalid, srst, sen, gap_set;
  logic [13:0] hi, lo;
  logic [2:0] wp, rp, poff, gap_val;
  logic [1:0] ssel;
  logic [7:0] ra [5] = '{8'h16, 8'h17, 8'h1b, 8'h1c, 8'h30};
  logic [7:0] re [5] = '{8'h00, 8'h04, 8'he4, 8'h00, 8'h00};
  int n_fail = 0;
  int checks = 0;
  // ==========================================
  // clock, watchdog well past the expected run
  initial
  begin
    forever #50 clk = ~clk;
  end
  initial
  begin
    #(3000 * 100);
    n_fail++;
    complete_run();
  end
  dac_input_fifo_datapath_regs dac_input_fifo_datapath_regs_inst (.clk(clk), .rst(rst),
    .reg_req(req), .rdata_r(rdata), .rvalid_r(rvalid), .lane_above_hi(hi), .lane_below_lo(lo),
    .fifo_wr_ptr(wp), .fifo_rd_ptr(rp), .fifo_soft_reset_r(srst), .fifo_phase_offset_r(poff),
    .strobe_delay_sel_r(ssel), .strobe_delay_en_r(sen), .dp_cfg_r(dp));
  fifo_ptr_model fifo_ptr_model_inst (.clk(clk), .rst(rst), .soft_reset(srst), .offset(poff),
    .gap_set(gap_set), .gap_val(gap_val), .wr_ptr(wp), .rd_ptr(rp));
  // ==========================================
  // tasks
  task automatic complete_run();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
    @(negedge clk);
  endtask
  // answer stands from the edge after the strobe, so it is sampled mid-cycle
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    chk({15'h0, rvalid}, 16'h0001);
    chk({8'h00, rdata & m}, {8'h00, exp & m});
    // one idle edge so a following call never re-raises rd in this time step
    @(negedge clk);
  endtask
  // ==========================================
  // test sequence
  initial
  begin
    req = '0;
    hi = '0;
    lo = '0;
    gap_set = 1'b0;
    gap_val = 3'h0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk({4'h0, dp}, 16'h0e90);
    chk({15'h0, sen}, 16'h0001);
    foreach (ra[i]) rdc(ra[i], re[i], 8'hff);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h16, 8'(i));
      chk({14'h0, ssel}, 16'(i));
      rdc(8'h16, 8'(i), 8'hff);
    end
    for (int g = 0; g < 8; g++)
    begin
      gap_set = 1'b1;
      gap_val = 3'(g);
      @(negedge clk);
      gap_set = 1'b0;
      rdc(8'h19, 8'((1 << g) - 1), 8'hff);
      rdc(8'h18, {g < 2 || g > 6, g < 3 || g > 5, 6'h0}, 8'hc0);
    end
    wr(8'h19, 8'h00);
    wr(8'h18, 8'hc4);
    rdc(8'h19, 8'h7f, 8'hff);
    rdc(8'h18, 8'hc0, 8'hc6);
    for (int k = 0; k < 2; k++)
    begin
      hi[3] = (k == 0);
      lo[9] = (k == 1);
      @(negedge clk);
      hi = '0;
      lo = '0;
      rdc(8'h15, k ? 8'h01 : 8'h02, 8'h03);
      rdc(8'h15, 8'h00, 8'h03);
    end
    wr(8'h17, 8'h03);
    chk({13'h0, poff}, 16'h0003);
    wr(8'h18, 8'h02);
    for (int n = 0; n < 20 && srst !== 1'b1; n++) @(negedge clk);
    chk({15'h0, srst}, 16'h0001);
    repeat (3) @(negedge clk);
    rdc(8'h18, 8'h06, 8'h06);
    rdc(8'h19, 8'h07, 8'hff);
    wr(8'h18, 8'h00);
    rdc(8'h18, 8'h04, 8'h06);
    wr(8'h17, 8'h04);
    wr(8'h1b, 8'hff);
    rdc(8'h1b, 8'hef, 8'hff);
    wr(8'h1b, 8'h0b);
    chk({4'h0, dp}, 16'h0160);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h1c, {5'h0, 2'(m), 1'b1});
      chk({12'h0, dp[3:0]}, {12'h0, 2'(m), m > 1, 1'b1});
    end
    complete_run();
  end
endmodule
